// ===== verilog/mss_top.sv
// Meter settings, means, extremes, mains frequency and display relay
`timescale 1ns/100ps
// Summary of operation
// - Link rate codes 0..4 give 9.6 to 115.2 kbps, default 4
// - Frames are 8 data bits, no parity, 2 stop bits sent
// - Averaging codes 0..8 map to 5 through 900 s, default 480 s
// - Separate averaging selectors for current, power and voltage means
// - Mean steps by a fraction of the error, 95 percent in time
// - All values recomputed every nine mains periods
// - Minimum and maximum follow every new extreme since last clear
// - All extremes saved to nonvolatile store every five minutes
// - Writing one to the clear location wipes all extremes together
// - Current mean maximum also clearable alone from the panel key
// - No voltage above 10 V in auto mode raises error 500
// - Without frequency, values continue but are flagged inaccurate
// - Error clears itself about five seconds after voltage returns
// - Mains frequency setting is 0 for auto or 45 to 65 Hz
// - A fixed frequency never raises the missing-frequency error
// - Harmonics covered up to forty times the mains frequency
// - Relay runs only with a changeover time above zero
// - After 60 s without keys the display relay takes over
// - One changeover time 0..60 s for all profiles, 0 stops stepping
// - Display and change profile selectors take codes 0 to 3
// - After power-up the first panel of the profile is shown
module mss_top import mss_pkg::*; #(
	parameter int unsigned SEC_CYCLES = SEC_CYCLES_DEF,
	parameter int unsigned NUM_PANELS = 8
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	// Register port
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [8:0]  reg_addr_i,
	input  wire logic [15:0] reg_wdata_i,
	output logic      [15:0] reg_rdata_o,
	output logic             reg_ack_o,
	output logic             reg_err_o,
	// Measurement front end
	input  wire logic        period_tick_i,
	input  wire mss_meas_t   meas_i,
	input  wire logic        volt_present_i,
	input  wire logic [6:0]  meas_freq_i,
	// Front panel
	input  wire logic        key_i,
	input  wire logic        clr_cur_max_i,
	input  wire logic        err_ack_i,
	// Settings, results and status
	output mss_cfg_t         cfg_o,
	output logic             calc_tick_o,
	output mss_meas_t        mean_o,
	output mss_meas_t        min_o,
	output mss_meas_t        max_o,
	output logic      [15:0] cur_mean_max_o,
	output logic             nv_save_o,
	output logic             freq_err_o,
	output logic             inaccurate_o,
	output logic      [6:0]  freq_eff_o,
	output logic      [11:0] harm_max_hz_o,
	output logic             relay_active_o,
	output logic      [7:0]  panel_o
);

	localparam logic [15:0] EMPTY_MIN = 16'h7FFF;
	localparam logic [15:0] EMPTY_MAX = 16'h8000;

	logic [31:0]  sec_cnt;
	logic         sec_tick;
	logic [3:0]   per_cnt;
	logic         xtr_clr;
	logic         wr_ok;
	logic         freq_auto;
	logic         freq_lost;
	logic [3:0]   rest_cnt;
	logic [8:0]   save_cnt;
	logic [5:0]   idle_cnt;
	logic [5:0]   step_cnt;
	logic         idle_done;
	logic         calc_d;
	mss_disp_t    disp_st;
	logic [47:0]  meas_vec;
	logic [47:0]  mean_vec;
	logic [47:0]  min_vec;
	logic [47:0]  max_vec;
	logic [3:0]   avg_sel [0:2];

	assign freq_auto = (cfg_o.mains_freq == 7'h00);
	assign meas_vec  = meas_i;
	assign avg_sel[0] = cfg_o.cur_avg;
	assign avg_sel[1] = cfg_o.pwr_avg;
	assign avg_sel[2] = cfg_o.volt_avg;
	assign xtr_clr = reg_wr_i && (reg_addr_i == OFS_XTR_CLEAR)
		&& (reg_wdata_i == XTR_CLEAR_CODE);

	// Range check of a write against the addressed setting
	always_comb begin
		unique case (reg_addr_i)
			OFS_NODE_ADDR: wr_ok = (reg_wdata_i >= 16'(NODE_ADDR_MIN))
				&& (reg_wdata_i <= 16'(NODE_ADDR_MAX));
			OFS_LINK_RATE: wr_ok = reg_wdata_i <= 16'(LINK_RATE_MAX);
			OFS_MAINS_FREQ: wr_ok = (reg_wdata_i == 16'h0000)
				|| ((reg_wdata_i >= 16'(FREQ_MIN))
				&& (reg_wdata_i <= 16'(FREQ_MAX)));
			OFS_DISP_PROF,
			OFS_CHG_PROF: wr_ok = reg_wdata_i <= 16'(PROFILE_MAX);
			OFS_CHG_TIME: wr_ok = reg_wdata_i <= 16'(CHG_TIME_MAX);
			OFS_CUR_AVG,
			OFS_PWR_AVG,
			OFS_VOLT_AVG: wr_ok = reg_wdata_i <= 16'(AVG_SEL_MAX);
			OFS_XTR_CLEAR: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	// Settings storage; refused writes keep the old value
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cfg_o.node_addr  <= RST_NODE_ADDR;
			cfg_o.link_rate  <= RST_LINK_RATE;
			cfg_o.data_bits  <= FRAME_DATA_BITS;
			cfg_o.tx_stop    <= FRAME_TX_STOP;
			cfg_o.mains_freq <= RST_MAINS_FREQ;
			cfg_o.disp_prof  <= RST_PROFILE;
			cfg_o.chg_prof   <= RST_PROFILE;
			cfg_o.chg_time   <= RST_CHG_TIME;
			cfg_o.cur_avg    <= RST_AVG_SEL;
			cfg_o.pwr_avg    <= RST_AVG_SEL;
			cfg_o.volt_avg   <= RST_AVG_SEL;
		end else begin
			cfg_o.data_bits <= FRAME_DATA_BITS;
			cfg_o.tx_stop   <= FRAME_TX_STOP;
			if (reg_wr_i && wr_ok) begin
				unique case (reg_addr_i)
					OFS_NODE_ADDR:  cfg_o.node_addr  <= reg_wdata_i[7:0];
					OFS_LINK_RATE:  cfg_o.link_rate  <= reg_wdata_i[2:0];
					OFS_MAINS_FREQ: cfg_o.mains_freq <= reg_wdata_i[6:0];
					OFS_DISP_PROF:  cfg_o.disp_prof  <= reg_wdata_i[1:0];
					OFS_CHG_PROF:   cfg_o.chg_prof   <= reg_wdata_i[1:0];
					OFS_CHG_TIME:   cfg_o.chg_time   <= reg_wdata_i[5:0];
					OFS_CUR_AVG:    cfg_o.cur_avg    <= reg_wdata_i[3:0];
					OFS_PWR_AVG:    cfg_o.pwr_avg    <= reg_wdata_i[3:0];
					OFS_VOLT_AVG:   cfg_o.volt_avg   <= reg_wdata_i[3:0];
					default: ;
				endcase
			end
		end
	end

	// Read data, acknowledge and refusal flag, one cycle after access
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= 16'h0000;
			reg_ack_o   <= 1'b0;
			reg_err_o   <= 1'b0;
		end else begin
			reg_ack_o <= reg_wr_i || reg_rd_i;
			reg_err_o <= reg_wr_i && !wr_ok;
			if (reg_rd_i) begin
				unique case (reg_addr_i)
					OFS_NODE_ADDR:  reg_rdata_o <= {8'h00, cfg_o.node_addr};
					OFS_LINK_RATE:  reg_rdata_o <= {13'h0000, cfg_o.link_rate};
					OFS_MAINS_FREQ: reg_rdata_o <= {9'h000, cfg_o.mains_freq};
					OFS_DISP_PROF:  reg_rdata_o <= {14'h0000, cfg_o.disp_prof};
					OFS_CHG_PROF:   reg_rdata_o <= {14'h0000, cfg_o.chg_prof};
					OFS_CHG_TIME:   reg_rdata_o <= {10'h000, cfg_o.chg_time};
					OFS_CUR_AVG:    reg_rdata_o <= {12'h000, cfg_o.cur_avg};
					OFS_PWR_AVG:    reg_rdata_o <= {12'h000, cfg_o.pwr_avg};
					OFS_VOLT_AVG:   reg_rdata_o <= {12'h000, cfg_o.volt_avg};
					OFS_STATUS: reg_rdata_o <= {13'h0000, relay_active_o,
						inaccurate_o, freq_err_o};
					default: reg_rdata_o <= 16'h0000;
				endcase
			end
		end
	end

	// One-second prescaler shared by all slow timers
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sec_cnt  <= 32'h0000_0000;
			sec_tick <= 1'b0;
		end else begin
			sec_tick <= (sec_cnt == 32'(SEC_CYCLES - 1));
			if (sec_cnt == 32'(SEC_CYCLES - 1))
				sec_cnt <= 32'h0000_0000;
			else
				sec_cnt <= sec_cnt + 32'h0000_0001;
		end
	end

	// Calculation pulse once every nine mains periods
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			per_cnt     <= 4'h0;
			calc_tick_o <= 1'b0;
		end else begin
			calc_tick_o <= period_tick_i && (per_cnt == CALC_PERIODS - 4'h1);
			if (period_tick_i)
				per_cnt <= (per_cnt == CALC_PERIODS - 4'h1) ? 4'h0
					: per_cnt + 4'h1;
		end
	end

	// Per quantity: exponential mean and extreme tracking
	for (genvar g = 0; g < 3; g++) begin : g_chan
		logic signed [31:0] acc;
		logic signed [32:0] diff;
		logic signed [15:0] x;
		assign x    = meas_vec[47-16*g -: 16];
		assign diff = 33'(signed'({x, 16'h0000})) - 33'(acc);

		// Mean moves by one N-th of the error on each calculation
		always_ff @(posedge clk_i or negedge rst_b_i) begin
			if (!rst_b_i)
				acc <= 32'h0000_0000;
			else if (calc_tick_o)
				acc <= acc + 32'(diff >>> AVG_SHIFT[avg_sel[g]]);
		end
		assign mean_vec[47-16*g -: 16] = acc[31:16];

		// Extremes; a sample in the clearing cycle seeds both
		always_ff @(posedge clk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				min_vec[47-16*g -: 16] <= EMPTY_MIN;
				max_vec[47-16*g -: 16] <= EMPTY_MAX;
			end else if (calc_tick_o) begin
				if (xtr_clr || x < signed'(min_vec[47-16*g -: 16]))
					min_vec[47-16*g -: 16] <= x;
				if (xtr_clr || x > signed'(max_vec[47-16*g -: 16]))
					max_vec[47-16*g -: 16] <= x;
			end else if (xtr_clr) begin
				min_vec[47-16*g -: 16] <= EMPTY_MIN;
				max_vec[47-16*g -: 16] <= EMPTY_MAX;
			end
		end
	end

	// Result outputs
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mean_o <= '0;
			min_o  <= '0;
			max_o  <= '0;
		end else begin
			mean_o <= mean_vec;
			min_o  <= min_vec;
			max_o  <= max_vec;
		end
	end

	// Maximum of the current mean, cleared by register or panel key;
	// judged one cycle after the calculation so the new mean is seen
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			calc_d         <= 1'b0;
			cur_mean_max_o <= EMPTY_MAX;
		end else begin
			calc_d <= calc_tick_o;
			if (calc_d && (xtr_clr || clr_cur_max_i
				|| signed'(mean_vec[47:32]) > signed'(cur_mean_max_o)))
				cur_mean_max_o <= mean_vec[47:32];
			else if (xtr_clr || clr_cur_max_i)
				cur_mean_max_o <= EMPTY_MAX;
		end
	end

	// Nonvolatile save pulse every five minutes
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			save_cnt  <= 9'h000;
			nv_save_o <= 1'b0;
		end else begin
			nv_save_o <= 1'b0;
			if (sec_tick) begin
				if (save_cnt == 9'(SAVE_TIME_S - 1)) begin
					save_cnt  <= 9'h000;
					nv_save_o <= 1'b1;
				end else
					save_cnt <= save_cnt + 9'h001;
			end
		end
	end

	// Missing-voltage error: raised on loss, acked, self-cleared
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			freq_lost    <= 1'b0;
			freq_err_o   <= 1'b0;
			inaccurate_o <= 1'b0;
			rest_cnt     <= 4'h0;
		end else begin
			inaccurate_o <= freq_lost || (freq_auto && !volt_present_i);
			if (!freq_auto) begin
				freq_lost  <= 1'b0;
				freq_err_o <= 1'b0;
				rest_cnt   <= 4'h0;
			end else if (!volt_present_i) begin
				rest_cnt  <= 4'h0;
				freq_lost <= 1'b1;
				if (!freq_lost)
					freq_err_o <= 1'b1;
				else if (err_ack_i)
					freq_err_o <= 1'b0;
			end else if (freq_lost) begin
				if (err_ack_i)
					freq_err_o <= 1'b0;
				if (sec_tick) begin
					if (rest_cnt == 4'(RESTORE_TIME_S - 1)) begin
						freq_lost  <= 1'b0;
						freq_err_o <= 1'b0;
						rest_cnt   <= 4'h0;
					end else
						rest_cnt <= rest_cnt + 4'h1;
				end
			end
		end
	end

	// Effective frequency: fixed setting or last good measurement
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			freq_eff_o    <= 7'h00;
			harm_max_hz_o <= 12'h000;
		end else begin
			if (!freq_auto)
				freq_eff_o <= cfg_o.mains_freq;
			else if (volt_present_i)
				freq_eff_o <= meas_freq_i;
			harm_max_hz_o <= 12'(HARM_ORDER_MAX) * {5'h00, freq_eff_o};
		end
	end

	// Key inactivity timer
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			idle_cnt  <= 6'h00;
			idle_done <= 1'b0;
		end else if (key_i) begin
			idle_cnt  <= 6'h00;
			idle_done <= 1'b0;
		end else if (sec_tick && !idle_done) begin
			if (idle_cnt == 6'(IDLE_TIME_S - 1))
				idle_done <= 1'b1;
			else
				idle_cnt <= idle_cnt + 6'h01;
		end
	end

	// Display: browse on keys, relay after idle, first panel at start
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			disp_st        <= DISP_BROWSE;
			panel_o        <= 8'h00;
			step_cnt       <= 6'h00;
			relay_active_o <= 1'b0;
		end else begin
			relay_active_o <= (disp_st == DISP_RELAY)
				&& (cfg_o.chg_time != 6'h00);
			unique case (disp_st)
				DISP_BROWSE: begin
					if (key_i)
						panel_o <= (panel_o == 8'(NUM_PANELS - 1)) ? 8'h00
							: panel_o + 8'h01;
					else if (idle_done && cfg_o.chg_time != 6'h00) begin
						disp_st  <= DISP_RELAY;
						step_cnt <= 6'h00;
					end
				end
				DISP_RELAY: begin
					if (key_i || cfg_o.chg_time == 6'h00)
						disp_st <= DISP_BROWSE;
					else if (sec_tick) begin
						if (step_cnt >= cfg_o.chg_time - 6'h01) begin
							step_cnt <= 6'h00;
							panel_o  <= (panel_o == 8'(NUM_PANELS - 1)) ? 8'h00
								: panel_o + 8'h01;
						end else
							step_cnt <= step_cnt + 6'h01;
					end
				end
			endcase
			if (reg_wr_i && wr_ok && (reg_addr_i == OFS_DISP_PROF
				|| reg_addr_i == OFS_CHG_PROF))
				panel_o <= 8'h00;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	property p_addr_range;
		cfg_o.node_addr >= 8'(NODE_ADDR_MIN)
			&& cfg_o.node_addr <= 8'(NODE_ADDR_MAX);
	endproperty
	a_addr_range: assert property (p_addr_range)
		else $error("node address out of range");

	property p_reject;
		reg_wr_i && !wr_ok |=> $stable(cfg_o);
	endproperty
	a_reject: assert property (p_reject)
		else $error("refused write changed a setting");

	property p_rate_range;
		cfg_o.link_rate <= 3'(LINK_RATE_MAX) && cfg_o.tx_stop == 2'h2;
	endproperty
	a_rate_range: assert property (p_rate_range)
		else $error("link rate or frame bad");

	property p_avg_range;
		cfg_o.cur_avg <= 4'h8 && cfg_o.pwr_avg <= 4'h8
			&& cfg_o.volt_avg <= 4'h8;
	endproperty
	a_avg_range: assert property (p_avg_range)
		else $error("averaging selector out of range");

	property p_calc_nine;
		period_tick_i && per_cnt == 4'h8 |=> calc_tick_o ##1 !calc_tick_o;
	endproperty
	a_calc_nine: assert property (p_calc_nine)
		else $error("calculation pulse missing");

	property p_minmax;
		calc_tick_o |=> signed'(min_vec[47:32]) <= signed'($past(meas_i.cur))
			&& signed'(max_vec[47:32]) >= signed'($past(meas_i.cur));
	endproperty
	a_minmax: assert property (p_minmax)
		else $error("extremes did not follow sample");

	property p_clear;
		xtr_clr && !calc_tick_o |=> min_vec[31:16] == EMPTY_MIN
			&& max_vec[15:0] == EMPTY_MAX;
	endproperty
	a_clear: assert property (p_clear)
		else $error("extremes not cleared");

	property p_fixed_noerr;
		!freq_auto ##1 !freq_auto |-> !freq_err_o;
	endproperty
	a_fixed_noerr: assert property (p_fixed_noerr)
		else $error("error raised at fixed frequency");

	property p_lost_err;
		freq_auto && !volt_present_i && !freq_lost |=> freq_err_o
			##1 inaccurate_o;
	endproperty
	a_lost_err: assert property (p_lost_err)
		else $error("missing voltage not flagged");

	property p_relay_off;
		cfg_o.chg_time == 6'h00 ##1 cfg_o.chg_time == 6'h00
			|-> !relay_active_o;
	endproperty
	a_relay_off: assert property (p_relay_off)
		else $error("relay active with zero changeover");

	c_relay: cover property (disp_st == DISP_RELAY && sec_tick);
	c_err_restore: cover property (freq_lost ##1 !freq_lost);
	c_save: cover property (nv_save_o);
	c_clear_calc: cover property (xtr_clr && calc_tick_o);

endmodule : mss_top

// ===== pkg/mss_pkg.sv
// Package: register map, settings limits, timing and carrier types
package mss_pkg;

	// Register offsets (word addresses on the register port)
	localparam logic [8:0] OFS_NODE_ADDR   = 9'h000;
	localparam logic [8:0] OFS_LINK_RATE   = 9'h001;
	localparam logic [8:0] OFS_MAINS_FREQ  = 9'h022;
	localparam logic [8:0] OFS_DISP_PROF   = 9'h025;
	localparam logic [8:0] OFS_CHG_PROF    = 9'h026;
	localparam logic [8:0] OFS_CHG_TIME    = 9'h027;
	localparam logic [8:0] OFS_CUR_AVG     = 9'h028;
	localparam logic [8:0] OFS_PWR_AVG     = 9'h029;
	localparam logic [8:0] OFS_VOLT_AVG    = 9'h02a;
	localparam logic [8:0] OFS_XTR_CLEAR   = 9'h1fa;
	localparam logic [8:0] OFS_STATUS      = 9'h1fb;

	// Status register field positions
	localparam int STAT_FREQ_ERR  = 0;
	localparam int STAT_INACCUR   = 1;
	localparam int STAT_RELAY     = 2;

	// Reset values
	localparam logic [7:0] RST_NODE_ADDR  = 8'h01;
	localparam logic [2:0] RST_LINK_RATE  = 3'h4;
	localparam logic [6:0] RST_MAINS_FREQ = 7'h00;
	localparam logic [1:0] RST_PROFILE    = 2'h0;
	localparam logic [5:0] RST_CHG_TIME   = 6'h00;
	localparam logic [3:0] RST_AVG_SEL    = 4'h6;

	// Setting limits
	localparam int NODE_ADDR_MIN = 1;
	localparam int NODE_ADDR_MAX = 247;
	localparam int LINK_RATE_MAX = 4;
	localparam int FREQ_MIN      = 45;
	localparam int FREQ_MAX      = 65;
	localparam int PROFILE_MAX   = 3;
	localparam int CHG_TIME_MAX  = 60;
	localparam int AVG_SEL_MAX   = 8;
	localparam logic [15:0] XTR_CLEAR_CODE = 16'h0001;

	// Fixed serial frame format
	localparam logic [3:0] FRAME_DATA_BITS = 4'h8;
	localparam logic [1:0] FRAME_TX_STOP   = 2'h2;

	// Mean shift per averaging code, sized for at least 95 percent
	// of a step after the set time at the slowest mains rate
	localparam logic [3:0] AVG_SHIFT [0:8] = '{4'h3, 4'h4, 4'h4, 4'h5,
		4'h6, 4'h8, 4'h9, 4'h9, 4'hA};

	// Cadence and timing
	localparam logic [3:0] CALC_PERIODS   = 4'h9;
	localparam int CLK_HZ          = 10_000_000;
	localparam int SEC_CYCLES_DEF  = CLK_HZ;
	localparam int SAVE_TIME_S     = 300;
	localparam int RESTORE_TIME_S  = 5;
	localparam int IDLE_TIME_S     = 60;
	localparam int HARM_ORDER_MAX  = 40;

	// Three measured quantities travelling together
	typedef struct packed {
		logic [15:0] cur;
		logic [15:0] pwr;
		logic [15:0] volt;
	} mss_meas_t;

	// Stored settings as seen by the rest of the meter
	typedef struct packed {
		logic [7:0] node_addr;
		logic [2:0] link_rate;
		logic [3:0] data_bits;
		logic [1:0] tx_stop;
		logic [6:0] mains_freq;
		logic [1:0] disp_prof;
		logic [1:0] chg_prof;
		logic [5:0] chg_time;
		logic [3:0] cur_avg;
		logic [3:0] pwr_avg;
		logic [3:0] volt_avg;
	} mss_cfg_t;

	typedef enum logic {
		DISP_BROWSE = 1'b0,
		DISP_RELAY  = 1'b1
	} mss_disp_t;

endpackage : mss_pkg

// ===== test/mss_master.sv
// Register-port master standing in for the parsed link traffic
`timescale 1ns/100ps
module mss_master (
	// Clock
	input  wire logic        clk_i,
	// Answer from the node
	input  wire logic [15:0] reg_rdata_i,
	input  wire logic        reg_ack_i,
	input  wire logic        reg_err_i,
	// Requests to the node
	output logic             reg_wr_o,
	output logic             reg_rd_o,
	output logic      [8:0]  reg_addr_o,
	output logic      [15:0] reg_wdata_o
);
	// Idle lines; no read or write requested
	initial begin
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = 9'h1ff;
		reg_wdata_o = 16'hffff;
	end
	// One access; callers use register offsets 0x000 to 0x1fb, 0x100 as unmapped probe
	task automatic xfer(input logic w, input logic [8:0] a,
		input logic [15:0] d, output logic [15:0] q, output logic e);
		@(posedge clk_i);
		#1;
		reg_wr_o = w;
		reg_rd_o = !w;
		reg_addr_o = a;
		reg_wdata_o = d;
		@(posedge clk_i);
		#1;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		q = reg_rdata_i;
		e = !reg_ack_i | (w & reg_err_i);
		reg_addr_o = ~a; // Released lines scrambled
		reg_wdata_o = ~d;
	endtask : xfer
endmodule : mss_master

// ===== test/tb.sv
// Self-checking bench for the meter settings block
`timescale 1ns/100ps
module tb import mss_pkg::*; ;
	logic        clk_i, rst_b_i, tick, vp, key, clr, ack_in;
	logic        wr, rd, ack, err, calc, save, ferr, inacc, relay;
	logic [8:0]  addr;
	logic [15:0] wd, rdat, cmm;
	logic [6:0]  mfreq, feff;
	logic [11:0] harm;
	logic [7:0]  panel;
	mss_meas_t   meas, mean, mn, mx;
	mss_cfg_t    cfg;
	int          failures = 0;
	int          comparisons = 0;
	int          cycles = 0;

	// Clock source
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	// Block under test with short seconds
	mss_top #(.SEC_CYCLES(10), .NUM_PANELS(8)) dut_u (.clk_i(clk_i),
		.rst_b_i(rst_b_i), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdat),
		.reg_ack_o(ack), .reg_err_o(err), .period_tick_i(tick),
		.meas_i(meas), .volt_present_i(vp), .meas_freq_i(mfreq),
		.key_i(key), .clr_cur_max_i(clr), .err_ack_i(ack_in),
		.cfg_o(cfg), .calc_tick_o(calc), .mean_o(mean), .min_o(mn),
		.max_o(mx), .cur_mean_max_o(cmm), .nv_save_o(save),
		.freq_err_o(ferr), .inaccurate_o(inacc), .freq_eff_o(feff),
		.harm_max_hz_o(harm), .relay_active_o(relay), .panel_o(panel));
	// Far-side master
	mss_master mst_u (.clk_i(clk_i), .reg_rdata_i(rdat),
		.reg_ack_i(ack), .reg_err_i(err), .reg_wr_o(wr),
		.reg_rd_o(rd), .reg_addr_o(addr), .reg_wdata_o(wd));

	// Verdict and end of run
	task automatic report_and_stop();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	// Hang guard
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			report_and_stop();
		end
	end
	// Compare and report
	task automatic chk(input string n, input logic [47:0] e,
		input logic [47:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : cyc
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask : pulse
	// Write with expected refusal flag, read with expected data
	task automatic wrc(input logic [8:0] a, input logic [15:0] d,
		input logic x);
		logic [15:0] q;
		logic        e;
		mst_u.xfer(1'b1, a, d, q, e);
		chk("wr_refused", 48'(x), 48'(e));
	endtask : wrc
	task automatic rdc(input logic [8:0] a, input logic [15:0] x);
		logic [15:0] q;
		logic        e;
		mst_u.xfer(1'b0, a, 16'h0000, q, e);
		chk("rd_ack", 0, 48'(e));
		chk("rd_data", 48'(x), 48'(q));
	endtask : rdc
	// Nine mains periods, then let the results land
	task automatic calc9();
		for (int i = 0; i < 9; i++) begin
			pulse(tick);
			chk("calc_tick", 48'(i == 8), 48'(calc));
			cyc(1);
		end
		cyc(4);
	endtask : calc9

	task automatic t_reset();
		chk("link", 4, 48'(cfg.link_rate));
		chk("bits", 8, 48'(cfg.data_bits));
		chk("stop", 2, 48'(cfg.tx_stop));
		chk("panel", 0, 48'(panel));
		rdc(OFS_CUR_AVG, 16'h0006);
		rdc(OFS_PWR_AVG, 16'h0006);
		$display("test reset done");
	endtask : t_reset

	task automatic t_regs();
		wrc(OFS_NODE_ADDR, 16'h00F7, 1'b0);
		wrc(OFS_NODE_ADDR, 16'h00F8, 1'b1);
		wrc(OFS_NODE_ADDR, 16'h0000, 1'b1);
		rdc(OFS_NODE_ADDR, 16'h00F7);
		for (int i = 0; i < 5; i++) begin
			wrc(OFS_LINK_RATE, 16'(i), 1'b0);
			chk("link", 48'(i), 48'(cfg.link_rate));
		end
		wrc(OFS_LINK_RATE, 16'h0005, 1'b1);
		for (int i = 0; i < 9; i++) begin
			wrc(OFS_CUR_AVG, 16'(i), 1'b0);
			wrc(OFS_PWR_AVG, 16'(8 - i), 1'b0);
			chk("cur_avg", 48'(i), 48'(cfg.cur_avg));
			chk("pwr_avg", 48'(8 - i), 48'(cfg.pwr_avg));
		end
		wrc(OFS_VOLT_AVG, 16'h0009, 1'b1);
		rdc(OFS_VOLT_AVG, 16'h0006);
		wrc(OFS_CHG_TIME, 16'h003D, 1'b1);
		wrc(OFS_CHG_TIME, 16'h003C, 1'b0);
		wrc(OFS_CHG_PROF, 16'h0004, 1'b1);
		wrc(OFS_CHG_PROF, 16'h0003, 1'b0);
		rdc(OFS_CHG_PROF, 16'h0003);
		wrc(9'h100, 16'h0001, 1'b1);
		rdc(9'h100, 16'h0000);
		$display("test registers done");
	endtask : t_regs

	task automatic t_freq();
		wrc(OFS_MAINS_FREQ, 16'h002C, 1'b1);
		wrc(OFS_MAINS_FREQ, 16'h0042, 1'b1);
		wrc(OFS_MAINS_FREQ, 16'h0041, 1'b0);
		wrc(OFS_MAINS_FREQ, 16'h0032, 1'b0);
		vp = 1'b0;
		mfreq = 7'd60;
		cyc(5);
		chk("ferr", 0, 48'(ferr));
		chk("harm", 2000, 48'(harm));
		wrc(OFS_MAINS_FREQ, 16'h0000, 1'b0);
		cyc(3);
		chk("ferr", 1, 48'(ferr));
		chk("inacc", 1, 48'(inacc));
		chk("feff", 50, 48'(feff));
		rdc(OFS_STATUS, 16'h0003);
		pulse(ack_in);
		cyc(2);
		chk("ferr", 0, 48'(ferr));
		chk("inacc", 1, 48'(inacc));
		vp = 1'b1;
		cyc(30);
		chk("inacc", 1, 48'(inacc));
		cyc(40);
		chk("inacc", 0, 48'(inacc));
		chk("feff", 60, 48'(feff));
		chk("harm", 2400, 48'(harm));
		$display("test frequency done");
	endtask : t_freq

	task automatic t_xtr();
		wrc(OFS_CUR_AVG, 16'h0000, 1'b0);
		meas = {16'd100, 16'd200, 16'd300};
		calc9();
		chk("mean_cur", 12, 48'(mean.cur));
		chk("min", {16'd100, 16'd200, 16'd300}, mn);
		meas = {16'd50, 16'd400, 16'd250};
		calc9();
		chk("min", {16'd50, 16'd200, 16'd250}, mn);
		chk("max", {16'd100, 16'd400, 16'd300}, mx);
		chk("cmm", 17, 48'(cmm));
		wrc(OFS_XTR_CLEAR, 16'h0002, 1'b0);
		cyc(2);
		chk("max", {16'd100, 16'd400, 16'd300}, mx);
		pulse(clr);
		cyc(2);
		chk("cmm", 16'h8000, 48'(cmm));
		chk("max", {16'd100, 16'd400, 16'd300}, mx);
		wrc(OFS_XTR_CLEAR, 16'h0001, 1'b0);
		cyc(2);
		chk("min", {3{16'h7FFF}}, mn);
		chk("max", {3{16'h8000}}, mx);
		$display("test extremes done");
	endtask : t_xtr

	task automatic t_save();
		int n;
		for (int k = 0; k < 2; k++) begin
			n = 0;
			cyc(1);
			while (save !== 1'b1 && n < 3100) begin
				cyc(1);
				n++;
			end
		end
		chk("save_gap", 1, 48'(n >= 2990 && n <= 3010));
		$display("test save done");
	endtask : t_save

	task automatic t_relay();
		wrc(OFS_CHG_TIME, 16'h0000, 1'b0);
		pulse(key);
		cyc(700);
		chk("relay", 0, 48'(relay));
		wrc(OFS_CHG_TIME, 16'h0002, 1'b0);
		pulse(key);
		cyc(570);
		chk("relay", 0, 48'(relay));
		cyc(50);
		chk("relay", 1, 48'(relay));
		wrc(OFS_DISP_PROF, 16'h0001, 1'b0);
		chk("panel", 0, 48'(panel));
		cyc(45);
		chk("panel_step", 1, 48'(panel != 8'h00));
		pulse(key);
		cyc(2);
		chk("relay", 0, 48'(relay));
		$display("test relay done");
	endtask : t_relay

	// Main sequence
	initial begin
		{rst_b_i, tick, key, clr, ack_in} = '0;
		vp = 1'b1;
		mfreq = 7'd50;
		meas = '0;
		repeat (8) @(posedge clk_i);
		#1;
		rst_b_i = 1'b1;
		t_reset();
		t_regs();
		t_freq();
		t_xtr();
		t_save();
		t_relay();
		report_and_stop();
	end
endmodule : tb
